// ---- hw/sgcs_pkg.sv ----
package sgcs_pkg;
   // Low address byte of the glue registers.
   localparam logic [7:0] SGCS_ADDR_PINMUX = 8'hDF;
   localparam logic [7:0] SGCS_ADDR_RAM_UB = 8'hE6;
   localparam logic [7:0] SGCS_ADDR_RAM_LB = 8'hE7;
   localparam logic [7:0] SGCS_ADDR_ROM_B = 8'hE8;
   // Pin multiplex select bit position.
   localparam int SGCS_PINMUX_BIT = 2;
   // Reset values.
   localparam logic [7:0] SGCS_PINMUX_RST = 8'h00;
   localparam logic [7:0] SGCS_RAM_UB_RST = 8'hFF;
   localparam logic [7:0] SGCS_RAM_LB_RST = 8'hF0;
   localparam logic [7:0] SGCS_ROM_B_RST = 8'hF0;
   // Auxiliary select window: address bits 7:6 equal to 2'b10.
   localparam logic [1:0] SGCS_AUX_A76 = 2'h2;
   // Refresh interval choices in system states.
   localparam logic [6:0] SGCS_REF_INT0 = 7'h0A;
   localparam logic [6:0] SGCS_REF_INT1 = 7'h14;
   localparam logic [6:0] SGCS_REF_INT2 = 7'h28;
   localparam logic [6:0] SGCS_REF_INT3 = 7'h50;
   // Least reset hold in system clock cycles (kept by the outside).
   localparam int SGCS_RESET_HOLD_CYC = 3;
   // Emulation modes.
   typedef enum logic [3:0] {
      SGCS_EMU_NORMAL = 4'h1,
      SGCS_EMU_ADAPTER = 4'h2,
      SGCS_EMU_PROBE = 4'h4,
      SGCS_EMU_TEST = 4'h8
   } sgcs_emu_t;
   // Wait sequencer states.
   typedef enum logic [1:0] {
      SGCS_W_IDLE = 2'h1,
      SGCS_W_COUNT = 2'h2
   } sgcs_wst_t;
endpackage

// ---- hw/sgcs_sync2.sv ----
`timescale 1ns/100ps
`default_nettype none
// Two flip-flop synchroniser for pin inputs.
module sgcs_sync2 #(
   parameter int W = 1
) (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta;

   // First stage feeds only the second stage.
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         meta <= '0;
         q <= '0;
      end else begin
         meta <= d;
         q <= meta;
      end
   end
endmodule
`default_nettype wire

// ---- hw/sgcs_glue.sv ----
// Contract
// - Auxiliary select low only for I/O cycles with low address 80-BF.
// - Auxiliary select ignores address bits 15 to 8.
// - Shared pin defaults to auxiliary select; mux bit 2 selects chain output.
// - Chain output high only with chain input high and no on-chip service.
// - Emulation pins decode to normal, adapter, probe and test modes.
// - RAM select low for memory cycles inside RAM boundary window.
// - ROM select low for memory cycles inside ROM region and outside RAM boundary window.
// - System clock output is a quarter or half of input rate by mode.
// - Bus enable output is a machine-cycle clock during transactions.
// - Status flag decodes cycle type together with halt.
// - Zero to three programmed wait states for memory, I/O and DMA.
// - Largest wait count among RAM, ROM and general generators wins.
// - Periodic refresh with 8-bit address, disable and period control.
// - Pin multiplex register read/write at low address DF.
// - RAM upper bound at E6, lower bound at E7, read/write.
// - ROM bound register read/write at low address E8.
`timescale 1ns/100ps
`default_nettype none
module sgcs_glue
   import sgcs_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic [15:0] addr,
   input wire logic [19:12] phys_addr_hi,
   input wire logic io_request_n,
   input wire logic memory_request_n,
   input wire logic opcode_fetch_cycle_n,
   input wire logic halt_n,
   input wire logic write_strobe,
   input wire logic [7:0] write_data,
   output logic [7:0] read_data,
   input wire logic chain_enable_in,
   input wire logic onchip_int_service,
   input wire logic emulation_select_low,
   input wire logic emulation_select_high,
   input wire logic clock_div_one,
   input wire logic cycle_status,
   input wire logic bus_cycle_active,
   input wire logic dma_cycle,
   input wire logic [1:0] general_wait,
   input wire logic [1:0] ram_wait,
   input wire logic [1:0] rom_wait,
   input wire logic refresh_enable,
   input wire logic [1:0] refresh_interval,
   output logic aux_io_select_n,
   output logic aux_pin_oe,
   output logic chain_enable_out,
   output logic ram_select_n,
   output logic rom_select_n,
   output logic system_clock_out,
   output logic bus_enable_clock,
   output logic machine_cycle_flag,
   output logic wait_n,
   output logic [3:0] emulation_mode,
   output logic refresh_request,
   output logic [7:0] refresh_address
);
   logic [7:0] pinmux;
   logic [7:0] ram_upper_bound;
   logic [7:0] ram_lower_bound;
   logic [7:0] rom_bound;
   logic [2:0] pins_sync;
   logic chain_in_s;
   logic emu_lo_s;
   logic emu_hi_s;
   logic io_cycle;
   logic aux_hit;
   logic [7:0] page;
   logic ram_hit;
   logic rom_hit;
   logic mem_cycle;
   logic phi_en;
   logic phi_div;
   logic bus_en;
   logic [1:0] next_wait_count;
   logic [1:0] wait_count;
   sgcs_wst_t wstate;
   logic cycle_d;
   logic [6:0] ref_timer;
   logic [6:0] ref_limit;
   sgcs_emu_t emu;

   // Chain and emulation pin inputs pass two flip-flops before use.
   sgcs_sync2 #(.W(3)) u_pins (
      .mclk(mclk),
      .rst_b(rst_b),
      .d({chain_enable_in, emulation_select_high, emulation_select_low}),
      .q(pins_sync)
   );
   assign chain_in_s = pins_sync[2];
   assign emu_hi_s = pins_sync[1];
   assign emu_lo_s = pins_sync[0];

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         pinmux <= SGCS_PINMUX_RST;
      end else if (io_cycle && write_strobe && addr[7:0] == SGCS_ADDR_PINMUX) begin
         pinmux <= write_data;
      end
   end

   // boundary registers, low byte decode only.
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         ram_upper_bound <= SGCS_RAM_UB_RST;
         ram_lower_bound <= SGCS_RAM_LB_RST;
         rom_bound <= SGCS_ROM_B_RST;
      end else if (io_cycle && write_strobe) begin
         if (addr[7:0] == SGCS_ADDR_RAM_UB) begin
            ram_upper_bound <= write_data;
         end
         if (addr[7:0] == SGCS_ADDR_RAM_LB) begin
            ram_lower_bound <= write_data;
         end
         if (addr[7:0] == SGCS_ADDR_ROM_B) begin
            rom_bound <= write_data;
         end
      end
   end

   // Registered read data; unmapped addresses read zero.
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         read_data <= 8'h00;
      end else begin
         case (addr[7:0])
            SGCS_ADDR_PINMUX: read_data <= pinmux;
            SGCS_ADDR_RAM_UB: read_data <= ram_upper_bound;
            SGCS_ADDR_RAM_LB: read_data <= ram_lower_bound;
            SGCS_ADDR_ROM_B: read_data <= rom_bound;
            default: read_data <= 8'h00;
         endcase
      end
   end

   // I/O cycle excludes interrupt acknowledge, where fetch is also low.
   assign io_cycle = !io_request_n && opcode_fetch_cycle_n;
   // auxiliary window decode uses only bits 7 and 6.
   assign aux_hit = io_cycle && (addr[7:6] == SGCS_AUX_A76);

   // shared pin function select; the pin is always driven.
   assign aux_pin_oe = 1'b1;
   // chain output gated by the chain input and on-chip service.
   assign chain_enable_out = pinmux[SGCS_PINMUX_BIT] && chain_in_s && !onchip_int_service;
   // auxiliary select appears only in its default pin function.
   assign aux_io_select_n = pinmux[SGCS_PINMUX_BIT] ? 1'b1 : !aux_hit;

   // memory selects from the top physical address byte.
   assign page = phys_addr_hi;
   assign mem_cycle = !memory_request_n;
   assign ram_hit = mem_cycle && page >= ram_lower_bound && page <= ram_upper_bound;
   assign rom_hit = mem_cycle && !ram_hit && page <= rom_bound;
   assign ram_select_n = !ram_hit;
   assign rom_select_n = !rom_hit;

   always_comb begin
      case ({emu_hi_s, emu_lo_s})
         2'h0: emu = SGCS_EMU_NORMAL;
         2'h1: emu = SGCS_EMU_ADAPTER;
         2'h2: emu = SGCS_EMU_PROBE;
         default: emu = SGCS_EMU_TEST;
      endcase
   end
   assign emulation_mode = emu;

   // system clock divider: toggles each cycle or follows the enable.
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         phi_div <= 1'b0;
      end else begin
         phi_div <= !phi_div;
      end
   end
   assign phi_en = clock_div_one ? 1'b1 : phi_div;

   // system clock output toggles on each rate enable, so divide by two halves its rate.
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         system_clock_out <= 1'b0;
      end else begin
         system_clock_out <= phi_en ? !system_clock_out : system_clock_out;
      end
   end

   // bus enable clock and status flag follow the machine cycle.
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         bus_en <= 1'b0;
         machine_cycle_flag <= 1'b0;
      end else if (phi_en) begin
         bus_en <= bus_cycle_active && !bus_en;
         machine_cycle_flag <= cycle_status && halt_n;
      end
   end
   assign bus_enable_clock = bus_en;

   // largest wait count among the applicable generators.
   always_comb begin
      next_wait_count = general_wait;
      if (ram_hit && ram_wait > next_wait_count) begin
         next_wait_count = ram_wait;
      end
      if (rom_hit && rom_wait > next_wait_count) begin
         next_wait_count = rom_wait;
      end
   end

   // wait sequencer, also for DMA cycles, starts at a cycle's rise.
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         wstate <= SGCS_W_IDLE;
         wait_count <= 2'h0;
         cycle_d <= 1'b0;
      end else if (phi_en) begin
         cycle_d <= mem_cycle || io_cycle || dma_cycle;
         case (wstate)
            SGCS_W_IDLE: begin
               if ((mem_cycle || io_cycle || dma_cycle) && !cycle_d && next_wait_count != 2'h0) begin
                  wait_count <= next_wait_count;
                  wstate <= SGCS_W_COUNT;
               end
            end
            SGCS_W_COUNT: begin
               wait_count <= wait_count - 2'h1;
               if (wait_count == 2'h1) begin
                  wstate <= SGCS_W_IDLE;
               end
            end
            default: wstate <= SGCS_W_IDLE;
         endcase
      end
   end
   assign wait_n = (wstate != SGCS_W_COUNT);

   always_comb begin
      case (refresh_interval)
         2'h0: ref_limit = SGCS_REF_INT0;
         2'h1: ref_limit = SGCS_REF_INT1;
         2'h2: ref_limit = SGCS_REF_INT2;
         default: ref_limit = SGCS_REF_INT3;
      endcase
   end

   // periodic refresh with an 8-bit incrementing address.
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         ref_timer <= 7'h00;
         refresh_request <= 1'b0;
         refresh_address <= 8'h00;
      end else begin
         refresh_request <= 1'b0;
         if (!refresh_enable) begin
            ref_timer <= 7'h00;
         end else if (phi_en) begin
            if (ref_timer + 7'h01 >= ref_limit) begin
               ref_timer <= 7'h00;
               refresh_request <= 1'b1;
               refresh_address <= refresh_address + 8'h01;
            end else begin
               ref_timer <= ref_timer + 7'h01;
            end
         end
      end
   end

   chain_gate_a: assert property (@(posedge mclk) disable iff (!rst_b)
      !chain_in_s |-> !chain_enable_out) else $error("chain output high with input low");
   chain_serv_a: assert property (@(posedge mclk) disable iff (!rst_b)
      onchip_int_service |-> !chain_enable_out) else $error("chain output high during service");
   aux_window_a: assert property (@(posedge mclk) disable iff (!rst_b)
      !aux_io_select_n |-> io_cycle && addr[7:6] == SGCS_AUX_A76) else $error("aux select outside window");
   aux_default_a: assert property (@(posedge mclk) disable iff (!rst_b)
      $rose(rst_b) |-> !pinmux[SGCS_PINMUX_BIT]) else $error("pin not default after reset");
   ram_window_a: assert property (@(posedge mclk) disable iff (!rst_b)
      !ram_select_n |-> mem_cycle && page >= ram_lower_bound && page <= ram_upper_bound)
      else $error("ram select outside window");
   rom_region_a: assert property (@(posedge mclk) disable iff (!rst_b)
      !rom_select_n |-> mem_cycle && page <= rom_bound) else $error("rom select outside region");
   wait_max_a: assert property (@(posedge mclk) disable iff (!rst_b)
      $fell(wait_n) |-> wait_count >= $past(general_wait) && (!$past(ram_hit) || wait_count >= $past(ram_wait))
      && (!$past(rom_hit) || wait_count >= $past(rom_wait))) else $error("wait count below a generator");
   phi_full_a: assert property (@(posedge mclk) disable iff (!rst_b)
      clock_div_one |=> $changed(system_clock_out)) else $error("system clock not toggling");
   phi_half_a: assert property (@(posedge mclk) disable iff (!rst_b)
      !clock_div_one && !$past(clock_div_one) && $past(rst_b) && $changed(system_clock_out)
      |=> $stable(system_clock_out)) else $error("system clock toggled on two cycles");
   emu_normal_a: assert property (@(posedge mclk) disable iff (!rst_b)
      !emu_hi_s && !emu_lo_s |-> emulation_mode == SGCS_EMU_NORMAL) else $error("emulation mode not normal");
   bus_idle_a: assert property (@(posedge mclk) disable iff (!rst_b)
      !bus_cycle_active && phi_en |=> !bus_enable_clock) else $error("bus enable high outside a transaction");
   ref_step_a: assert property (@(posedge mclk) disable iff (!rst_b)
      refresh_request |-> refresh_address == $past(refresh_address) + 8'h01)
      else $error("refresh address did not step");
   mux_write_a: assert property (@(posedge mclk) disable iff (!rst_b)
      io_cycle && write_strobe && addr[7:0] == SGCS_ADDR_PINMUX |=> pinmux == $past(write_data))
      else $error("pin multiplex write lost");
endmodule
`default_nettype wire

// ---- sim/sgcs_chain_src.sv ----
`timescale 1ns/100ps
`default_nettype none
// Upstream chain source and power-on reset source for the glue block.
module sgcs_chain_src (
   input wire logic mclk,
   input wire logic upstream_en,
   input wire logic busy,
   output logic chain_out,
   output logic rst_b
);
   logic [1:0] rst_cnt = 2'h0;
   always_ff @(posedge mclk) begin
      if (rst_cnt != 2'h3) begin
         rst_cnt <= rst_cnt + 2'h1;
      end
   end
   assign rst_b = (rst_cnt == 2'h3);
   // A busy upstream peripheral blocks everything below it.
   always_ff @(posedge mclk) begin
      chain_out <= upstream_en & ~busy;
   end
endmodule
`default_nettype wire

// ---- sim/system_glue_chip_select_bench.sv ----
`timescale 1ns/100ps
`default_nettype none
module system_glue_chip_select_bench;
   import sgcs_pkg::*;
   logic mclk, rst_b, io_request_n, memory_request_n, opcode_fetch_cycle_n, halt_n, write_strobe;
   logic chain_enable_in, onchip_int_service, emulation_select_low, emulation_select_high, clock_div_one;
   logic cycle_status, bus_cycle_active, dma_cycle, refresh_enable, up_en, up_busy;
   logic [15:0] addr;
   logic [7:0] phys_addr_hi, write_data, read_data, refresh_address;
   logic [1:0] general_wait, ram_wait, rom_wait, refresh_interval;
   logic aux_io_select_n, aux_pin_oe, chain_enable_out, ram_select_n, rom_select_n, system_clock_out;
   logic bus_enable_clock, machine_cycle_flag, wait_n, refresh_request;
   logic [3:0] emulation_mode;
   int err_total = 0;
   int check_count = 0;
   sgcs_glue i_dut (
      .mclk(mclk), .rst_b(rst_b), .addr(addr), .phys_addr_hi(phys_addr_hi), .io_request_n(io_request_n),
      .memory_request_n(memory_request_n), .opcode_fetch_cycle_n(opcode_fetch_cycle_n), .halt_n(halt_n),
      .write_strobe(write_strobe), .write_data(write_data), .read_data(read_data),
      .chain_enable_in(chain_enable_in), .onchip_int_service(onchip_int_service),
      .emulation_select_low(emulation_select_low), .emulation_select_high(emulation_select_high),
      .clock_div_one(clock_div_one), .cycle_status(cycle_status), .bus_cycle_active(bus_cycle_active),
      .dma_cycle(dma_cycle), .general_wait(general_wait), .ram_wait(ram_wait), .rom_wait(rom_wait),
      .refresh_enable(refresh_enable), .refresh_interval(refresh_interval), .aux_io_select_n(aux_io_select_n),
      .aux_pin_oe(aux_pin_oe), .chain_enable_out(chain_enable_out), .ram_select_n(ram_select_n),
      .rom_select_n(rom_select_n), .system_clock_out(system_clock_out), .bus_enable_clock(bus_enable_clock),
      .machine_cycle_flag(machine_cycle_flag), .wait_n(wait_n), .emulation_mode(emulation_mode),
      .refresh_request(refresh_request), .refresh_address(refresh_address)
   );
   sgcs_chain_src i_src (.mclk(mclk), .upstream_en(up_en), .busy(up_busy), .chain_out(chain_enable_in),
      .rst_b(rst_b));
   // Compares one value and counts the outcome.
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      check_count++;
      if (g !== e) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge mclk);
      {addr, write_data, write_strobe, io_request_n} <= {a, d, 2'h2};
      @(posedge mclk);
      {write_strobe, io_request_n} <= 2'h1;
   endtask
   task automatic rd(input logic [15:0] a, input logic [7:0] e);
      @(posedge mclk);
      {addr, io_request_n} <= {a, 1'b0};
      repeat (2) @(posedge mclk);
      #1 chk("read_data", e, read_data);
      @(posedge mclk);
      io_request_n <= 1'b1;
   endtask
   task automatic t_regs();
      logic [15:0] ra[4] = '{16'h5ADF, 16'h5AE6, 16'h5AE7, 16'h5AE8};
      logic [7:0] rv[4] = '{SGCS_PINMUX_RST, SGCS_RAM_UB_RST, SGCS_RAM_LB_RST, SGCS_ROM_B_RST};
      logic [7:0] wv[4] = '{8'h00, 8'h7F, 8'h40, 8'h1F};
      for (int i = 0; i < 4; i++) begin
         rd(ra[i], rv[i]);
         wr(ra[i], wv[i]);
         rd({8'hC3, ra[i][7:0]}, wv[i]);
      end
      wr(16'h00E5, 8'hAA);
      rd(16'h00E5, 8'h00);
      $display("registers done");
   endtask
   task automatic t_aux();
      logic [15:0] a[7] = '{16'h007F, 16'h0080, 16'h12BF, 16'hFFC0, 16'hAB9C, 16'h0080, 16'h0080};
      logic [1:0] c[7] = '{2'h1, 2'h1, 2'h1, 2'h1, 2'h1, 2'h0, 2'h3};
      logic e[7] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
      for (int i = 0; i < 7; i++) begin
         @(posedge mclk);
         {addr, io_request_n, opcode_fetch_cycle_n} <= {a[i], c[i]};
         @(posedge mclk);
         #1 chk("aux_io_select_n", 8'(e[i]), 8'(aux_io_select_n));
         chk("aux_pin_oe", 8'h01, 8'(aux_pin_oe));
      end
      @(posedge mclk);
      {io_request_n, opcode_fetch_cycle_n} <= 2'h3;
      $display("aux select done");
   endtask
   task automatic t_chain();
      logic [2:0] v[4] = '{3'h4, 3'h5, 3'h0, 3'h6};
      logic e[4] = '{1'b1, 1'b0, 1'b0, 1'b0};
      @(posedge mclk);
      {up_en, up_busy, onchip_int_service} <= 3'h4;
      repeat (5) @(posedge mclk);
      #1 chk("chain_enable_out", 8'h00, 8'(chain_enable_out));
      wr(16'h00DF, 8'h04);
      for (int i = 0; i < 4; i++) begin
         @(posedge mclk);
         {up_en, up_busy, onchip_int_service} <= v[i];
         repeat (5) @(posedge mclk);
         #1 chk("chain_enable_out", 8'(e[i]), 8'(chain_enable_out));
      end
      @(posedge mclk);
      {addr, io_request_n} <= {16'h0080, 1'b0};
      @(posedge mclk);
      #1 chk("aux_io_select_n", 8'h01, 8'(aux_io_select_n));
      @(posedge mclk);
      io_request_n <= 1'b1;
      wr(16'h00DF, 8'h00);
      $display("chain done");
   endtask
   task automatic t_emu();
      for (int i = 0; i < 4; i++) begin
         @(posedge mclk);
         {emulation_select_high, emulation_select_low} <= 2'(i);
         repeat (4) @(posedge mclk);
         #1 chk("emulation_mode", 8'(4'h1 << i), 8'(emulation_mode));
      end
      $display("emulation done");
   endtask
   task automatic t_mem();
      logic [7:0] pg[7] = '{8'h10, 8'h1F, 8'h20, 8'h40, 8'h7F, 8'h80, 8'h50};
      logic [2:0] ex[7] = '{3'h2, 3'h2, 3'h3, 3'h1, 3'h1, 3'h3, 3'h7};
      for (int i = 0; i < 7; i++) begin
         @(posedge mclk);
         {phys_addr_hi, memory_request_n} <= {pg[i], ex[i][2]};
         @(posedge mclk);
         #1 chk("ram_rom_select_n", 8'(ex[i][1:0]), 8'({ram_select_n, rom_select_n}));
      end
      $display("memory selects done");
   endtask
   // Runs one memory cycle and counts the inserted wait cycles.
   task automatic mem_wait(input logic [7:0] pg, input logic [5:0] w, input logic [7:0] e);
      int n = 0;
      @(posedge mclk);
      {phys_addr_hi, general_wait, ram_wait, rom_wait} <= {pg, w};
      @(posedge mclk);
      // A DMA cycle runs on the same bus cycle as its memory request.
      {memory_request_n, bus_cycle_active, dma_cycle} <= {2'h1, w[0]};
      repeat (20) begin
         @(posedge mclk);
         #1 n += (wait_n === 1'b0);
      end
      @(posedge mclk);
      {memory_request_n, bus_cycle_active, dma_cycle} <= 3'h4;
      chk("wait_count", e, 8'(n));
   endtask
   task automatic toggles(input logic d, input logic [7:0] e);
      int n = 0;
      logic p;
      @(posedge mclk);
      clock_div_one <= d;
      repeat (4) @(posedge mclk);
      #1 p = system_clock_out;
      repeat (16) begin
         @(posedge mclk);
         #1 n += (system_clock_out !== p);
         p = system_clock_out;
      end
      chk("clock_toggles", e, 8'(n));
   endtask
   // Checks the bus enable clock and the cycle status flag.
   task automatic t_bus();
      int n = 0;
      logic p;
      @(posedge mclk);
      {cycle_status, halt_n, bus_cycle_active} <= 3'h7;
      repeat (3) @(posedge mclk);
      #1 chk("machine_cycle_flag", 8'h01, 8'(machine_cycle_flag));
      p = bus_enable_clock;
      repeat (8) begin
         @(posedge mclk);
         #1 n += (bus_enable_clock !== p);
         p = bus_enable_clock;
      end
      chk("bus_enable_toggles", 8'h08, 8'(n));
      @(posedge mclk);
      {cycle_status, bus_cycle_active} <= 2'h0;
      repeat (3) @(posedge mclk);
      #1 chk("bus_enable_clock", 8'h00, 8'(bus_enable_clock));
      chk("machine_cycle_flag", 8'h00, 8'(machine_cycle_flag));
      $display("bus cycle outputs done");
   endtask
   task automatic wait_ref(output int t);
      t = 0;
      do begin
         @(posedge mclk);
         #1 t++;
         if (t > 400) begin
            err_total++;
            $display("[FAIL] refresh_request expected pulse seen none");
            summarize();
         end
      end while (refresh_request !== 1'b1);
   endtask
   task automatic t_ref();
      logic [6:0] iv[4] = '{SGCS_REF_INT0, SGCS_REF_INT1, SGCS_REF_INT2, SGCS_REF_INT3};
      int t;
      logic [7:0] a;
      for (int i = 0; i < 4; i++) begin
         @(posedge mclk);
         {refresh_enable, refresh_interval} <= {1'b1, 2'(i)};
         wait_ref(t);
         wait_ref(t);
         a = refresh_address;
         wait_ref(t);
         chk("refresh_spacing", 8'(iv[i]), 8'(t));
         chk("refresh_address", a + 8'h01, refresh_address);
      end
      @(posedge mclk);
      refresh_enable <= 1'b0;
      repeat (2) @(posedge mclk);
      t = 0;
      repeat (200) begin
         @(posedge mclk);
         #1 t += refresh_request;
      end
      chk("refresh_off", 8'h00, 8'(t));
      $display("refresh done");
   endtask
   // Free-running 250 MHz clock.
   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end
   // Main sequence; the chain source holds reset for the first three cycles.
   initial begin
      {io_request_n, memory_request_n, opcode_fetch_cycle_n, halt_n, write_strobe} = 5'h1E;
      {addr, phys_addr_hi, write_data} = 32'h0;
      {onchip_int_service, emulation_select_low, emulation_select_high, clock_div_one} = 4'h1;
      {cycle_status, bus_cycle_active, dma_cycle, refresh_enable, up_en, up_busy} = 6'h0;
      {general_wait, ram_wait, rom_wait, refresh_interval} = 8'h0;
      repeat (5) @(posedge mclk);
      t_regs();
      t_aux();
      t_chain();
      t_emu();
      t_mem();
      mem_wait(8'h50, 6'h1E, 8'h03);
      mem_wait(8'h10, 6'h1E, 8'h02);
      mem_wait(8'h90, 6'h1E, 8'h01);
      mem_wait(8'h90, 6'h0F, 8'h00);
      mem_wait(8'h10, 6'h3F, 8'h03);
      t_ref();
      t_bus();
      toggles(1'b0, 8'h08);
      toggles(1'b1, 8'h10);
      $display("wait and clock done");
      summarize();
   end
endmodule
`default_nettype wire
